/* File: rtl/lbc_link_behavior.sv */
// Function
// - Far-end drop set in forced 100 mode: disable transmitter on link loss.
// - Bit 6 set shortens parallel-detect link-up; clear keeps normal timing.
// - Fast or robust crossover mode selected forces fast link-up bit on.
// - Bit 5 set with partner forced 100: link runs full duplex.
// - Bit 5 clear: duplex follows the standard decision, nothing forced.
// - Bit 4 set: link LED only on 100 full duplex; clear: any link.
// - Enhanced LED set: activity blink setting ignored, LED never blinks.
// - Bit 3 set: isolate MII outputs on 100 half-duplex link.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module lbc_link_behavior (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire lbc_pkg::lbc_phy_in_s phy_in,
    output lbc_pkg::lbc_phy_out_s phy_out
);
    import lbc_pkg::*;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } lbc_bus_e;

    lbc_bus_e bus_q;
    lbc_bus_e bus_d;
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] ctrl_eff;
    logic [8:0] sync_w;
    lbc_phy_in_s s;
    logic take;
    logic [31:0] rdata_d;
    logic fd;
    logic link_100;
    logic tx_off;
    logic led;
    logic isolate;
    lbc_phy_out_s phy_d;

    // Every pin level passes two flip-flops before any logic reads it.
    lbc_sync u_sync (
        .clock(clock),
        .srst(srst),
        .d(phy_in),
        .q(sync_w)
    );

    assign s = lbc_phy_in_s'(sync_w);

    // Byte lanes pick the written bytes; bits 2:0 always keep their old value.
    function automatic logic [15:0] lbc_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        lbc_merge = (r & LBC_WMASK) | (old & ~LBC_WMASK);
    endfunction : lbc_merge

    // Compares a word index with one register offset.
    function automatic logic lbc_hit(input logic [3:0] addr, input logic [3:0] ofs);
        lbc_hit = (addr == ofs);
    endfunction : lbc_hit

    // True for an established link at 100 Mb/s.
    function automatic logic lbc_link_100(input lbc_phy_in_s p);
        lbc_link_100 = p.link_up & p.speed_100;
    endfunction : lbc_link_100

    // Either crossover mode forces the fast link-up bit on, whatever software wrote.
    always_comb begin
        ctrl_eff = ctrl_q;
        if (s.fast_mdix || s.robust_mdix) begin
            ctrl_eff[LBC_BIT_FAST_PD] = 1'b1;
        end
    end

    // A request is taken on the first edge it is seen and answered one cycle later.
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    // State register of the bus handshake.
    always_ff @(posedge clock) begin
        if (srst) begin
            bus_q <= BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    // Waitrequest is a flip-flop of its own, low exactly while the answer stands.
    always_ff @(posedge clock) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= (bus_d != BUS_ANSWER);
        end
    end

    // The answer cycle is the one in which waitrequest is low.
    always_comb begin
        take = (bus_q == BUS_ANSWER);
    end

    // A write lands on the answer edge, while the request still stands.
    always_comb begin
        ctrl_d = ctrl_q;
        if (take && avs_write && lbc_hit(avs_address, LBC_OFS_LINK_BEHAVIOR_CONTROL)) begin
            ctrl_d = lbc_merge(ctrl_q, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q <= LBC_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read data are loaded on the taking edge and stand through the answer cycle.
    always_comb begin
        if (lbc_hit(avs_address, LBC_OFS_LINK_BEHAVIOR_CONTROL)) begin
            rdata_d = {16'h0000, ctrl_eff};
        end else if (lbc_hit(avs_address, LBC_OFS_STATUS)) begin
            rdata_d = {27'h0, phy_out};
        end else begin
            rdata_d = LBC_UNMAPPED;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !take) begin
            avs_readdata <= rdata_d;
        end
    end

    // Extended full duplex only overrides the standard decision against a forced 100 partner.
    always_comb begin
        fd = s.ieee_full_duplex;
        if (ctrl_q[LBC_BIT_EXT_FD] && s.partner_forced_100) begin
            fd = 1'b1;
        end
    end

    always_comb begin
        link_100 = lbc_link_100(s);
    end

    // Far-end link drop only acts in forced 100 mode, and holds the transmitter off while link is down.
    always_comb begin
        tx_off = 1'b0;
        if (ctrl_q[LBC_BIT_FAR_DROP] && s.forced_100) begin
            tx_off = ~s.link_up;
        end
    end

    // The enhanced link LED ignores the blink setting, so activity never blinks it.
    always_comb begin
        if (ctrl_q[LBC_BIT_ENH_LED]) begin
            led = link_100 & fd;
        end else begin
            led = s.link_up & ~(s.blink_enable & s.activity);
        end
    end

    // Isolation applies only to a half-duplex link at 100 Mb/s.
    always_comb begin
        isolate = 1'b0;
        if (ctrl_q[LBC_BIT_ISO_HD] && link_100 && !fd) begin
            isolate = 1'b1;
        end
    end

    always_comb begin
        phy_d.tx_disable = tx_off;
        phy_d.fast_pd_linkup = ctrl_eff[LBC_BIT_FAST_PD];
        phy_d.full_duplex = fd;
        phy_d.link_led = led;
        phy_d.mii_isolate = isolate;
    end

    // All link outputs leave through one register stage.
    always_ff @(posedge clock) begin
        if (srst) begin
            phy_out.tx_disable <= 1'b0;
            phy_out.fast_pd_linkup <= 1'b0;
            phy_out.full_duplex <= 1'b0;
            phy_out.link_led <= 1'b0;
            phy_out.mii_isolate <= 1'b0;
        end else begin
            phy_out <= phy_d;
        end
    end
endmodule : lbc_link_behavior

/* File: rtl/lbc_pkg.sv */
package lbc_pkg;
    localparam logic [3:0] LBC_ADDR_W = 4'h4;
    localparam logic [3:0] LBC_OFS_LINK_BEHAVIOR_CONTROL = 4'ha;
    localparam logic [3:0] LBC_OFS_STATUS = 4'hc;
    localparam int LBC_BIT_FAR_DROP = 15;
    localparam int LBC_BIT_FAST_PD = 6;
    localparam int LBC_BIT_EXT_FD = 5;
    localparam int LBC_BIT_ENH_LED = 4;
    localparam int LBC_BIT_ISO_HD = 3;
    localparam logic [15:0] LBC_RESET = 16'h0100;
    localparam logic [15:0] LBC_WMASK = 16'hfff8;
    localparam logic [31:0] LBC_UNMAPPED = 32'hdeadbeef;

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic forced_100;
        logic partner_forced_100;
        logic ieee_full_duplex;
        logic activity;
        logic blink_enable;
        logic fast_mdix;
        logic robust_mdix;
    } lbc_phy_in_s;

    typedef struct packed {
        logic tx_disable;
        logic fast_pd_linkup;
        logic full_duplex;
        logic link_led;
        logic mii_isolate;
    } lbc_phy_out_s;
endpackage : lbc_pkg

/* File: rtl/lbc_sync.sv */
`timescale 1ns/10ps
module lbc_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic [8:0] d,
    output logic [8:0] q
);
    logic [8:0] meta_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= 9'h000;
            q <= 9'h000;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : lbc_sync

/* File: verif/lbc_link_behavior_monitor.sv */
`timescale 1ns/10ps
module lbc_mon import lbc_pkg::*; (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire lbc_phy_in_s phy_in,
    input wire lbc_phy_out_s phy_out
);
    logic [26:0] h_q;
    logic [15:0] c_q, k_q;
    lbc_phy_in_s p;
    lbc_phy_out_s o;
    logic l, f;
    assign p = h_q[26:18];
    assign o = phy_out;
    assign l = p.link_up & p.speed_100;
    assign f = o.full_duplex;
    always_ff @(posedge clock) begin
        h_q <= {h_q[17:0], phy_in};
        k_q <= c_q;
        if (srst) c_q <= LBC_RESET;
        else if (avs_write && !avs_waitrequest && avs_address == LBC_OFS_LINK_BEHAVIOR_CONTROL)
            c_q <= avs_writedata[15:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    far_drop_a: assert property (o.tx_disable == (k_q[15] & p.forced_100 & !p.link_up)) else $error("tx");
    fast_pd_a: assert property (!p.fast_mdix && !p.robust_mdix |-> o.fast_pd_linkup == k_q[6])
        else $error("pd");
    mdix_pd_a: assert property (p.fast_mdix || p.robust_mdix |-> o.fast_pd_linkup) else $error("mdix");
    ext_fd_a: assert property (k_q[5] && p.partner_forced_100 |-> f) else $error("efd");
    std_fd_a: assert property (!k_q[5] |-> f == p.ieee_full_duplex) else $error("fd");
    enh_led_a: assert property (k_q[4] |-> o.link_led == (l & f)) else $error("led");
    std_led_a: assert property (!k_q[4] |-> o.link_led == (p.link_up & !(p.blink_enable & p.activity)))
        else $error("lstd");
    no_blink_a: assert property (k_q[4] && l && f && p.activity && p.blink_enable |-> o.link_led)
        else $error("blink");
    iso_hd_a: assert property (o.mii_isolate == (k_q[3] & l & !f)) else $error("iso");
endmodule : lbc_mon
bind lbc_link_behavior lbc_mon mon (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .phy_in(phy_in), .phy_out(phy_out));

/* File: verif/tb_lbc_link_behavior.sv */
`timescale 1ns/10ps
module tb_lbc_link_behavior;
    import lbc_pkg::*;
    logic clock = 1'h0, srst = 1'h1, rd = 1'h0, wr = 1'h0, wt;
    logic [3:0] ad = 4'h0;
    logic [31:0] wd = 32'h0, rq, got;
    logic [15:0] lf = 16'h2b, cv = 16'h0;
    lbc_phy_in_s pi = '0;
    lbc_phy_out_s po;
    int bad_count = 0, checks_done = 0;
    lbc_link_behavior dut (.clock(clock), .srst(srst), .avs_address(ad), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rq), .avs_waitrequest(wt), .phy_in(pi), .phy_out(po));
    initial forever #2.5 clock = ~clock;
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    function automatic logic [31:0] rb(logic [15:0] c, lbc_phy_in_s p);
        return {16'h0, c & LBC_WMASK | 16'(p.fast_mdix | p.robust_mdix) << 6};
    endfunction : rb
    function automatic lbc_phy_out_s ex(logic [15:0] c, lbc_phy_in_s p);
        lbc_phy_out_s o;
        o.full_duplex = p.ieee_full_duplex | c[LBC_BIT_EXT_FD] & p.partner_forced_100;
        o.tx_disable = c[LBC_BIT_FAR_DROP] & p.forced_100 & !p.link_up;
        o.fast_pd_linkup = c[LBC_BIT_FAST_PD] | p.fast_mdix | p.robust_mdix;
        o.mii_isolate = c[LBC_BIT_ISO_HD] & p.link_up & p.speed_100 & !o.full_duplex;
        o.link_led = c[LBC_BIT_ENH_LED] ? p.link_up & p.speed_100 & o.full_duplex
            : p.link_up & !(p.blink_enable & p.activity);
        return o;
    endfunction : ex
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks_done++;
        if (g !== e) bad_count++;
        if (g !== e) $display("mismatch %0t %h %h", $time, g, e);
    endtask : chk
    task automatic bus(logic w, logic [3:0] a);
        @(posedge clock);
        {rd, wr} <= {!w, w};
        ad <= a;
        wd <= {16'h0, cv};
        do @(posedge clock); while (wt !== 1'h0);
        got = rq;
        {rd, wr} <= 2'h0;
    endtask : bus
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'h0;
        bus(1'h0, 4'h3);
        chk(got, LBC_UNMAPPED);
        bus(1'h0, 4'ha);
        chk(got, {16'h0, LBC_RESET});
        repeat (300) begin
            lf = nx(lf);
            cv = got[15:0] & 16'h7f80 | lf & 16'h807f;
            bus(1'h1, 4'ha);
            lf = nx(lf);
            pi <= lbc_phy_in_s'(lf[8:0]);
            repeat (4) @(posedge clock);
            bus(1'h0, 4'ha);
            chk(got, rb(cv, pi));
            bus(1'h0, LBC_OFS_STATUS);
            chk(got, {27'h0, ex(cv, pi)});
            chk({27'h0, po}, {27'h0, ex(cv, pi)});
        end
        wrap_up();
    end
endmodule : tb_lbc_link_behavior
